// >>> verilog/lpmc_regs.vh
`ifndef LPMC_REGS_VH
`define LPMC_REGS_VH
// Mode codes
`define LPMC_MODE_ACTIVE    3'h0
`define LPMC_MODE_STANDBY   3'h1
`define LPMC_MODE_STOP      3'h2
`define LPMC_MODE_WATCH     3'h3
`define LPMC_MODE_SUBACTIVE 3'h4
// Register byte offsets
`define LPMC_OFF_CTRL   12'h000
`define LPMC_OFF_CMD    12'h004
`define LPMC_OFF_STATUS 12'h008
`define LPMC_OFF_IRQ    12'h00C
// Control register fields
`define LPMC_CTRL_WATCH_SEL 0
`define LPMC_CTRL_LOW_SPEED 1
`define LPMC_CTRL_DIRECT    2
`define LPMC_CTRL_IE        3
// Command register fields (write-one pulses)
`define LPMC_CMD_STOP    0
`define LPMC_CMD_STANDBY 1
// Reset values
`define LPMC_CTRL_RST 4'h0
// Settle time in ns and derived cycles at 25 MHz
`define LPMC_SETTLE_NS   32'd1000
`define LPMC_CLK_NS      32'd40
`define LPMC_SETTLE_CYC  ((`LPMC_SETTLE_NS + `LPMC_CLK_NS - 32'd1) / `LPMC_CLK_NS)
`endif

// >>> verilog/lpmc_sync.v
`timescale 1ns/10ps
// Two-flop synchroniser for one asynchronous level
module lpmc_sync
(
    input  wire clk,
    input  wire rst,
    input  wire din,
    output reg  dout
);
    reg meta_q;

    // First stage feeds only the second
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end
        else
        begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// >>> verilog/lpmc_top.v
// Function
// - Five modes: active, standby, stop, watch, subactive, by running clocks.
// - Reset release or interrupt enters active; CPU on main oscillator.
// - Standby instruction in active enters standby.
// - Standby stops CPU clock; peripherals, timers, serial keep running.
// - Reset ending standby gives a full reset.
// - Interrupt ends standby, back to active, next instruction follows.
// - Wake interrupt serviced if enable flag is 1, else stays pending.
// - Stop instruction with watch select 0 enters stop; main osc halts.
// - Stop instruction with watch select 1 enters watch mode.
// - Peripheral clock on in active/standby/subactive; CPU in active/sub.
// - Stop resets CPU, timers, serial, display; outputs high impedance.
// - After stop RAM intact; CPU data registers need not be valid.
// - Watch: timer A and display run; timers B, C, serial stop.
// - Watch: external-clock serial still shifts but raises no interrupt.
// - Ext interrupt 0 or timer A in watch enters subactive on subclock.
// - Subactive support is a build option; otherwise unreachable.
// - Watch wake goes to active if low speed flag 0, else subactive.
// - Stop/standby with IE 0 and unmasked flag pending acts as no-op.
// - Asynchronous reset resets the device from any mode.
// - Stop/standby in subactive goes to watch or active by flags.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "lpmc_regs.vh"
module lpmc_top
#(
    parameter SUBACTIVE_EN = 1
)
(
    input  wire        core_clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        irq_pending,
    input  wire        ext_interrupt_0,
    input  wire        timer_a_irq,
    input  wire        serial_ext_clk_mode,
    input  wire        serial_irq_in,
    output reg         cpu_clk_en,
    output reg         peripheral_clock_en,
    output reg         timebase_clk_en,
    output reg         main_osc_en,
    output reg         cpu_on_subclock,
    output reg         timer_a_run,
    output reg         timer_bc_run,
    output reg         serial_run,
    output reg         display_run,
    output reg         core_reset,
    output reg         io_hold,
    output reg         io_out_en,
    output reg         serial_irq_out,
    output reg         wake_service
);
    reg  [2:0] mode_q;
    reg  [2:0] mode_d;
    reg  [3:0] ctrl_q;
    reg        cmd_stop;
    reg        cmd_sby;
    reg        wake_pend_q;
    wire       wake_any;
    wire       wake_watch;
    wire       nop_cond;
    wire       wr_en;
    wire       rd_en;
    wire       ext_interrupt_0_s;
    wire       tma_s;
    wire       irq_s;
    wire       sub_ok;

    assign sub_ok = (SUBACTIVE_EN != 0);

    // Wake request inputs resynchronised before use; serial inputs used directly
    lpmc_sync u_sync_ext_interrupt_0
    (
        .clk  (core_clk),
        .rst  (rst),
        .din  (ext_interrupt_0),
        .dout (ext_interrupt_0_s)
    );
    lpmc_sync u_sync_tma
    (
        .clk  (core_clk),
        .rst  (rst),
        .din  (timer_a_irq),
        .dout (tma_s)
    );
    lpmc_sync u_sync_irq
    (
        .clk  (core_clk),
        .rst  (rst),
        .din  (irq_pending),
        .dout (irq_s)
    );

    // APB strobes, zero wait state
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    assign wake_any   = irq_s | ext_interrupt_0_s | tma_s;
    assign wake_watch = ext_interrupt_0_s | tma_s;
    assign nop_cond   = ~ctrl_q[`LPMC_CTRL_IE] & irq_s;

    // Instruction strobes decoded from command writes
    always @*
    begin
        cmd_stop = wr_en & (paddr == `LPMC_OFF_CMD)
                   & pwdata[`LPMC_CMD_STOP];
        cmd_sby  = wr_en & (paddr == `LPMC_OFF_CMD)
                   & pwdata[`LPMC_CMD_STANDBY];
    end

    // Next-mode decision
    always @*
    begin
        mode_d = mode_q;
        case (mode_q)
            `LPMC_MODE_ACTIVE:
            begin
                if ((cmd_stop | cmd_sby) & nop_cond)
                    mode_d = mode_q;
                else if (cmd_stop & ctrl_q[`LPMC_CTRL_WATCH_SEL])
                    mode_d = `LPMC_MODE_WATCH;
                else if (cmd_stop)
                    mode_d = `LPMC_MODE_STOP;
                else if (cmd_sby)
                    mode_d = `LPMC_MODE_STANDBY;
            end
            `LPMC_MODE_STANDBY:
            begin
                if (wake_any)
                    mode_d = `LPMC_MODE_ACTIVE;
            end
            `LPMC_MODE_STOP:
            begin
                mode_d = mode_q;
            end
            `LPMC_MODE_WATCH:
            begin
                if (wake_watch & ctrl_q[`LPMC_CTRL_LOW_SPEED] & sub_ok)
                    mode_d = `LPMC_MODE_SUBACTIVE;
                else if (wake_watch)
                    mode_d = `LPMC_MODE_ACTIVE;
            end
            `LPMC_MODE_SUBACTIVE:
            begin
                if ((cmd_stop | cmd_sby) & nop_cond)
                    mode_d = mode_q;
                else if ((cmd_stop | cmd_sby)
                         & ctrl_q[`LPMC_CTRL_DIRECT]
                         & ~ctrl_q[`LPMC_CTRL_LOW_SPEED])
                    mode_d = `LPMC_MODE_ACTIVE;
                else if (cmd_stop | cmd_sby)
                    mode_d = `LPMC_MODE_WATCH;
            end
            default:
            begin
                mode_d = `LPMC_MODE_ACTIVE;
            end
        endcase
    end

    // Mode register, async reset to active
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
            mode_q <= `LPMC_MODE_ACTIVE;
        else
            mode_q <= mode_d;
    end

    // Control bits; direct flag only writable in subactive
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ctrl_q <= `LPMC_CTRL_RST;
        else if (mode_d == `LPMC_MODE_ACTIVE
                 && mode_q != `LPMC_MODE_ACTIVE)
            ctrl_q[`LPMC_CTRL_DIRECT] <= 1'b0;
        else if (wr_en && paddr == `LPMC_OFF_CTRL)
        begin
            ctrl_q[`LPMC_CTRL_WATCH_SEL] <= pwdata[`LPMC_CTRL_WATCH_SEL];
            ctrl_q[`LPMC_CTRL_LOW_SPEED] <= pwdata[`LPMC_CTRL_LOW_SPEED];
            ctrl_q[`LPMC_CTRL_IE]        <= pwdata[`LPMC_CTRL_IE];
            if (mode_q == `LPMC_MODE_SUBACTIVE)
                ctrl_q[`LPMC_CTRL_DIRECT] <= pwdata[`LPMC_CTRL_DIRECT];
        end
    end

    // Wake servicing: resume, then service only if enabled
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wake_pend_q  <= 1'b0;
            wake_service <= 1'b0;
        end
        else
        begin
            if (mode_q == `LPMC_MODE_STANDBY
                && mode_d == `LPMC_MODE_ACTIVE)
                wake_pend_q <= 1'b1;
            else if (~irq_s)
                wake_pend_q <= 1'b0;
            wake_service <= wake_pend_q & irq_s
                            & ctrl_q[`LPMC_CTRL_IE];
        end
    end

    // Clock gates and block controls decoded from mode
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cpu_clk_en          <= 1'b0;
            peripheral_clock_en <= 1'b0;
            timebase_clk_en     <= 1'b0;
            main_osc_en         <= 1'b1;
            cpu_on_subclock     <= 1'b0;
            timer_a_run         <= 1'b0;
            timer_bc_run        <= 1'b0;
            serial_run          <= 1'b0;
            display_run         <= 1'b0;
            core_reset          <= 1'b1;
            io_hold             <= 1'b0;
            io_out_en           <= 1'b0;
            serial_irq_out      <= 1'b0;
        end
        else
        begin
            cpu_clk_en <= (mode_d == `LPMC_MODE_ACTIVE)
                          | (mode_d == `LPMC_MODE_SUBACTIVE);
            peripheral_clock_en <= (mode_d == `LPMC_MODE_ACTIVE)
                                   | (mode_d == `LPMC_MODE_STANDBY)
                                   | (mode_d == `LPMC_MODE_SUBACTIVE);
            timebase_clk_en <= (mode_d != `LPMC_MODE_STOP);
            main_osc_en <= (mode_d == `LPMC_MODE_ACTIVE)
                           | (mode_d == `LPMC_MODE_STANDBY);
            cpu_on_subclock <= (mode_d == `LPMC_MODE_SUBACTIVE);
            timer_a_run  <= (mode_d != `LPMC_MODE_STOP);
            display_run  <= (mode_d != `LPMC_MODE_STOP);
            timer_bc_run <= (mode_d != `LPMC_MODE_STOP)
                            & (mode_d != `LPMC_MODE_WATCH);
            serial_run   <= ((mode_d != `LPMC_MODE_STOP)
                             & (mode_d != `LPMC_MODE_WATCH))
                            | ((mode_d == `LPMC_MODE_WATCH)
                               & serial_ext_clk_mode);
            serial_irq_out <= serial_irq_in
                              & (mode_d != `LPMC_MODE_WATCH)
                              & (mode_d != `LPMC_MODE_STOP);
            // Stop resets core logic, RAM untouched
            core_reset <= (mode_d == `LPMC_MODE_STOP);
            io_out_en  <= (mode_d != `LPMC_MODE_STOP);
            io_hold    <= (mode_d == `LPMC_MODE_STANDBY)
                          | (mode_d == `LPMC_MODE_WATCH);
        end
    end

    // APB read data and response
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable
                       & (paddr != `LPMC_OFF_CTRL)
                       & (paddr != `LPMC_OFF_CMD)
                       & (paddr != `LPMC_OFF_STATUS)
                       & (paddr != `LPMC_OFF_IRQ);
            prdata <= 32'h00000000;
            if (psel & ~penable & ~pwrite)
            begin
                case (paddr)
                    `LPMC_OFF_CTRL:
                        prdata <= {28'h0000000, ctrl_q};
                    `LPMC_OFF_STATUS:
                        prdata <= {28'h0000000, sub_ok, mode_q};
                    `LPMC_OFF_IRQ:
                        prdata <= {29'h00000000, tma_s, ext_interrupt_0_s, irq_s};
                    default:
                        prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// >>> bench/lpmc_checker.sv
`timescale 1ns/10ps
module lpmc_checker
(
    input wire core_clk,
    input wire rst,
    input wire ext_interrupt_0,
    input wire timer_a_irq,
    input wire serial_ext_clk_mode,
    input wire cpu_clk_en,
    input wire peripheral_clock_en,
    input wire timebase_clk_en,
    input wire main_osc_en,
    input wire cpu_on_subclock,
    input wire timer_a_run,
    input wire timer_bc_run,
    input wire serial_run,
    input wire display_run,
    input wire core_reset,
    input wire io_out_en,
    input wire serial_irq_out
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // Mode decode seen from the gate outputs
    wire act = cpu_clk_en && !cpu_on_subclock;
    wire in_watch = !peripheral_clock_en && timebase_clk_en;
    wire in_stop = !peripheral_clock_en && !timebase_clk_en && !main_osc_en;
    // Watch wake: request held through the synchroniser, then leave
    sequence s_wake;
        (in_watch && (ext_interrupt_0 || timer_a_irq))[*3];
    endsequence
    sequence s_leave;
        ##[1:2] !in_watch;
    endsequence

    active_gates_a: assert property (act |-> peripheral_clock_en &&
        timebase_clk_en && main_osc_en && io_out_en && !core_reset)
        else $error("active mode gates wrong");
    standby_gates_a: assert property (!cpu_clk_en && peripheral_clock_en
        |-> timebase_clk_en && main_osc_en && timer_bc_run && serial_run)
        else $error("standby mode gates wrong");
    stop_gates_a: assert property (in_stop |-> core_reset &&
        !io_out_en && !timer_a_run && !serial_run && !display_run)
        else $error("stop mode outputs wrong");
    stop_sticky_a: assert property (in_stop |=> in_stop)
        else $error("stop left without reset");
    watch_gates_a: assert property (in_watch |-> timer_a_run &&
        display_run && !timer_bc_run && !main_osc_en &&
        serial_run == $past(serial_ext_clk_mode))
        else $error("watch mode gates wrong");
    watch_wake_a: assert property (s_wake |-> s_leave)
        else $error("watch not left on wake request");
    sub_clock_a: assert property (cpu_on_subclock |-> cpu_clk_en &&
        peripheral_clock_en && !main_osc_en)
        else $error("subactive gates wrong");
    cpu_needs_per_a: assert property (cpu_clk_en |-> peripheral_clock_en)
        else $error("cpu clock without peripheral clock");
    serial_gate_a: assert property ($fell(peripheral_clock_en)
        ##1 !peripheral_clock_en |-> !serial_irq_out)
        else $error("serial interrupt not gated");
endmodule

bind lpmc_top lpmc_checker lpmc_checker_i (.core_clk, .rst,
    .ext_interrupt_0, .timer_a_irq, .serial_ext_clk_mode,
    .cpu_clk_en, .peripheral_clock_en,
    .timebase_clk_en, .main_osc_en, .cpu_on_subclock, .timer_a_run,
    .timer_bc_run, .serial_run, .display_run, .core_reset, .io_out_en,
    .serial_irq_out);

// >>> bench/testbench.sv
`timescale 1ns/10ps
`include "lpmc_regs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module testbench;
    logic        core_clk, rst, psel, penable, pwrite, irq_pending;
    logic        ext_interrupt_0, timer_a_irq, serial_ext_clk_mode;
    logic        serial_irq_in;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready, pslverr, cpu_clk_en, peripheral_clock_en;
    wire         timebase_clk_en, main_osc_en, core_reset, io_out_en;
    logic [38:0] notes[$];
    logic [38:0] exp_v;
    logic [7:0]  lf = 8'h59;
    int          fail_count, checks_done;
    wire  [38:0] got_v;
    // Gates per mode: cpu, per, timebase, osc, core reset, io enable
    localparam logic [5:0] GT [5] = '{6'h3D, 6'h1D, 6'h02, 6'h09, 6'h39};

    lpmc_top lpmc_top_i (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq_pending, .ext_interrupt_0,
        .timer_a_irq, .serial_ext_clk_mode, .serial_irq_in, .cpu_clk_en,
        .peripheral_clock_en, .timebase_clk_en, .main_osc_en,
        .cpu_on_subclock(), .timer_a_run(), .timer_bc_run(), .serial_run(),
        .display_run(), .core_reset, .io_hold(), .io_out_en,
        .serial_irq_out(), .wake_service());
    // Observed word: response, gates, read data
    assign got_v = {pslverr, cpu_clk_en, peripheral_clock_en,
        timebase_clk_en, main_osc_en, core_reset, io_out_en, prdata};

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // One APB transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [11:0] a, input logic [38:0] e);
        notes.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask
    task automatic st(input logic [2:0] m);
        rd(`LPMC_OFF_STATUS, {1'b0, GT[m], 28'h0, 1'b1, m});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    // Idle gap with random serial inputs
    task automatic gap(input int n);
        lf = lfsr(lf);
        {serial_irq_in, serial_ext_clk_mode} <= lf[1:0];
        repeat (n + lf[2]) @(posedge core_clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Read monitor: oldest note against status, gates and data
    always @(posedge core_clk)
        if (psel && penable && pready && !pwrite)
        begin
            exp_v = notes.pop_front();
            `CHK(got_v, exp_v)
        end
    initial
    begin
        #120000;
        fail_count++;
        tally_and_finish();
    end
    // Main sequence
    initial
    begin
        {rst, psel, penable, pwrite, irq_pending} = 5'h10;
        {ext_interrupt_0, timer_a_irq} = 2'b00;
        {serial_ext_clk_mode, serial_irq_in} = 2'b00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        st(`LPMC_MODE_ACTIVE);
        rd(12'h010, {1'b1, GT[0], 32'h0});
        wr(`LPMC_OFF_STATUS, {4{lfsr(lf)}});
        st(`LPMC_MODE_ACTIVE);
        wr(`LPMC_OFF_CTRL, 32'h8);
        wr(`LPMC_OFF_CMD, 32'h2);
        st(`LPMC_MODE_STANDBY);
        irq_pending <= 1'b1;
        gap(6);
        st(`LPMC_MODE_ACTIVE);
        rd(`LPMC_OFF_CTRL, {1'b0, GT[0], 32'h8});
        wr(`LPMC_OFF_CTRL, 32'h0);
        wr(`LPMC_OFF_CMD, 32'h2);
        st(`LPMC_MODE_ACTIVE);
        irq_pending <= 1'b0;
        gap(4);
        wr(`LPMC_OFF_CTRL, 32'h1);
        wr(`LPMC_OFF_CMD, 32'h1);
        st(`LPMC_MODE_WATCH);
        timer_a_irq <= 1'b1;
        gap(6);
        st(`LPMC_MODE_ACTIVE);
        timer_a_irq <= 1'b0;
        gap(4);
        wr(`LPMC_OFF_CTRL, 32'h3);
        wr(`LPMC_OFF_CMD, 32'h1);
        st(`LPMC_MODE_WATCH);
        ext_interrupt_0 <= 1'b1;
        gap(6);
        st(`LPMC_MODE_SUBACTIVE);
        ext_interrupt_0 <= 1'b0;
        gap(4);
        wr(`LPMC_OFF_CTRL, 32'h2);
        wr(`LPMC_OFF_CMD, 32'h2);
        st(`LPMC_MODE_WATCH);
        ext_interrupt_0 <= 1'b1;
        gap(6);
        st(`LPMC_MODE_SUBACTIVE);
        ext_interrupt_0 <= 1'b0;
        gap(4);
        wr(`LPMC_OFF_CTRL, 32'h4);
        wr(`LPMC_OFF_CMD, 32'h1);
        st(`LPMC_MODE_ACTIVE);
        rd(`LPMC_OFF_CTRL, {1'b0, GT[0], 32'h0});
        wr(`LPMC_OFF_CMD, 32'h1);
        st(`LPMC_MODE_STOP);
        {timer_a_irq, irq_pending} <= 2'b11;
        gap(8);
        st(`LPMC_MODE_STOP);
        {timer_a_irq, irq_pending} <= 2'b00;
        rst <= 1'b1;
        repeat (`LPMC_SETTLE_CYC) @(posedge core_clk);
        rst <= 1'b0;
        st(`LPMC_MODE_ACTIVE);
        wr(`LPMC_OFF_CTRL, 32'h8);
        wr(`LPMC_OFF_CMD, 32'h2);
        st(`LPMC_MODE_STANDBY);
        rst <= 1'b1;
        gap(2);
        rst <= 1'b0;
        rd(`LPMC_OFF_CTRL, {1'b0, GT[0], 32'h0});
        gap(2);
        `CHK(notes.size(), 0)
        tally_and_finish();
    end
endmodule
